// ===== tmr_regbank.sv
`timescale 1ns/1ns
`default_nettype none
module tmr_regbank
#(
    parameter logic [6:0] DEV_ADDR    = 7'h2a,
    parameter int         TIMEOUT_CYC = tmr_pkg::TIMEOUT_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output var  logic        sda_out,
    output var  logic        sda_oe,
    input  wire logic [7:0]  local_temp_in,
    input  wire logic [12:0] remote_temp_in,
    input  wire logic        diode_fault_in,
    input  wire logic        remote_crit_in,
    input  wire logic        conversion_rate_code_done,
    input  wire logic [1:0]  remote_filter_select,
    input  wire logic        enhanced_resolution_select,
    output var  logic        conversion_rate_code_start,
    output var  logic        busy,
    output var  logic [7:0]  config_out,
    output var  logic [3:0]  conversion_rate_code,
    output var  logic [7:0]  local_high_limit_bits,
    output var  logic [7:0]  remote_high_limit_bits,
    output var  logic [7:0]  remote_low_limit_bits,
    output var  logic [7:0]  remote_offset_bits
);
    import tmr_pkg::*;

    tmr_bus_ev_t ev;
    tmr_state_t  state_q;
    tmr_state_t  after_ack_q;
    logic [3:0]  cnt_q;
    logic [7:0]  sh_q;
    logic [7:0]  rd_sh_q;
    logic [7:0]  ptr_q;
    logic        sda_oe_q;
    logic        sda_out_q;
    logic [7:0]  cfg_q;
    logic [3:0]  rate_q;
    logic [7:0]  lhl_q;
    logic [7:0]  rhl_q;
    logic [7:0]  rll_q;
    logic [7:0]  rofs_q;
    logic [7:0]  local_q;
    logic [12:0] remote_q;
    logic [7:0]  status_q;
    logic        conversion_rate_code_start_q;

    tmr_bus_watch #(
        .TIMEOUT_CYC (TIMEOUT_CYC)
    ) u_watch (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .ev      (ev)
    );

    wire [7:0] rx_byte   = {sh_q[6:0], ev.sda};
    wire       last_bit  = ev.scl_rise && (cnt_q == 4'h7);
    wire       addr_hit  = (rx_byte[7:1] == DEV_ADDR);
    wire       wr_stb    = (state_q == ST_WDATA) && last_bit;
    wire       abort     = ev.stop || ev.timeout;

    // Alias offsets fold onto the primary register before any decode.
    wire [7:0] phys_ptr = (ptr_q == REG_CFG_ALIAS)  ? REG_CFG  :
                          (ptr_q == REG_RATE_ALIAS) ? REG_RATE :
                          (ptr_q == REG_LHL_ALIAS)  ? REG_LHL  :
                          (ptr_q == REG_RHL_ALIAS)  ? REG_RHL  :
                          (ptr_q == REG_RLL_ALIAS)  ? REG_RLL  : ptr_q;

    wire filt_on = (remote_filter_select != 2'h0) || enhanced_resolution_select;
    wire [7:0] frac_byte = filt_on ? {remote_q[4:0], 3'h0}
                                   : {remote_q[4:2], 5'h00};

    wire wr_cfg   = wr_stb && (phys_ptr == REG_CFG);
    wire wr_rate  = wr_stb && (phys_ptr == REG_RATE);
    wire wr_lhl   = wr_stb && (phys_ptr == REG_LHL);
    wire wr_rhl   = wr_stb && (phys_ptr == REG_RHL);
    wire wr_rll   = wr_stb && (phys_ptr == REG_RLL);
    wire wr_rofs  = wr_stb && (phys_ptr == REG_ROFS);
    // Only the access in standby matters; the written byte is never looked at here.
    wire one_shot = wr_stb && (phys_ptr == REG_ONESHOT) && cfg_q[CFG_STANDBY_SELECT];

    // The trigger offset, reserved and unmapped offsets all read as zero.
    wire [7:0] rd_data = (phys_ptr == REG_LOCAL)  ? local_q :
                         (phys_ptr == REG_REMOTE_OVER_LIMIT_FLAG)  ? remote_q[12:5] :
                         (phys_ptr == REG_STATUS) ? status_q :
                         (phys_ptr == REG_CFG)    ? cfg_q :
                         (phys_ptr == REG_RATE)   ? {4'h0, rate_q} :
                         (phys_ptr == REG_LHL)    ? lhl_q :
                         (phys_ptr == REG_RHL)    ? rhl_q :
                         (phys_ptr == REG_RLL)    ? rll_q :
                         (phys_ptr == REG_RFRAC)  ? frac_byte :
                         (phys_ptr == REG_ROFS)   ? rofs_q : 8'h00;

    wire lover = $signed(local_temp_in) > $signed(lhl_q);
    wire rover = $signed(remote_temp_in[12:5]) > $signed(rhl_q);
    wire runder = $signed(remote_temp_in[12:5]) < $signed(rll_q);

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q     <= ST_IDLE;
            after_ack_q <= ST_IDLE;
            cnt_q       <= 4'h0;
            sh_q        <= 8'h00;
            rd_sh_q     <= 8'h00;
            ptr_q       <= 8'h00;
            sda_oe_q    <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ev.start)
            begin
                state_q  <= ST_ADDR;
                cnt_q    <= 4'h0;
                sda_oe_q <= 1'b0;
            end
            else if (abort)
            begin
                state_q  <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end
            else
            begin
                unique case (state_q)
                    ST_IDLE:
                    begin
                        cnt_q <= 4'h0;
                    end
                    ST_ADDR, ST_CMD, ST_WDATA:
                    begin
                        if (ev.scl_rise)
                        begin
                            sh_q  <= rx_byte;
                            cnt_q <= cnt_q + 4'h1;
                        end
                        if (last_bit)
                        begin
                            state_q <= ST_ACK;
                            if (state_q == ST_ADDR)
                            begin
                                state_q     <= addr_hit ? ST_ACK : ST_IDLE;
                                after_ack_q <= rx_byte[0] ? ST_RDATA : ST_CMD;
                                rd_sh_q     <= rd_data;
                            end
                            else if (state_q == ST_CMD)
                            begin
                                ptr_q       <= rx_byte;
                                after_ack_q <= ST_WDATA;
                            end
                            else
                            begin
                                after_ack_q <= ST_WDATA;
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        if (ev.scl_fall)
                        begin
                            cnt_q <= 4'h0;
                            if (!sda_oe_q)
                            begin
                                sda_oe_q <= 1'b1;
                            end
                            else if (after_ack_q == ST_RDATA)
                            begin
                                state_q  <= ST_RDATA;
                                sda_oe_q <= ~rd_sh_q[7];
                                rd_sh_q  <= {rd_sh_q[6:0], 1'b0};
                            end
                            else
                            begin
                                state_q  <= after_ack_q;
                                sda_oe_q <= 1'b0;
                            end
                        end
                    end
                    ST_RDATA:
                    begin
                        if (ev.scl_rise)
                        begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                        else if (ev.scl_fall)
                        begin
                            if (cnt_q == 4'h8)
                            begin
                                state_q  <= ST_RACK;
                                sda_oe_q <= 1'b0;
                            end
                            else
                            begin
                                sda_oe_q <= ~rd_sh_q[7];
                                rd_sh_q  <= {rd_sh_q[6:0], 1'b0};
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        // A master ACK repeats the same register; NACK ends the read.
                        if (ev.scl_rise)
                        begin
                            state_q <= ev.sda ? ST_IDLE : ST_RDATA;
                            cnt_q   <= 4'h0;
                            rd_sh_q <= rd_data;
                        end
                    end
                    default:
                    begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_q  <= RST_CFG;
            rate_q <= RST_RATE[RATE_W-1:0];
            lhl_q  <= RST_LHL;
            rhl_q  <= RST_RHL;
            rll_q  <= RST_RLL;
            rofs_q <= RST_ROFS;
        end
        else if (clk_en)
        begin
            if (wr_cfg)  cfg_q  <= rx_byte & 8'he7;
            if (wr_rate) rate_q <= rx_byte[RATE_W-1:0];
            if (wr_lhl)  lhl_q  <= rx_byte;
            if (wr_rhl)  rhl_q  <= rx_byte;
            if (wr_rll)  rll_q  <= rx_byte;
            if (wr_rofs) rofs_q <= rx_byte;
        end
    end

    // Results and limit flags are captured only at the end of a conversion.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            local_q      <= 8'h00;
            remote_q     <= 13'h0000;
            status_q     <= 8'h00;
            conversion_rate_code_start_q <= 1'b0;
            sda_out_q    <= 1'b0;
        end
        else if (clk_en)
        begin
            conversion_rate_code_start_q <= one_shot;
            if (conversion_rate_code_done)
            begin
                local_q  <= local_temp_in;
                remote_q <= remote_temp_in;
                status_q[6:1] <= {lover, 1'b0, rover, runder, diode_fault_in, remote_crit_in};
            end
            // A trigger landing on the completing cycle keeps busy set.
            if (one_shot)
                status_q[STAT_BUSY] <= 1'b1;
            else if (conversion_rate_code_done)
                status_q[STAT_BUSY] <= 1'b0;
        end
    end

    assign sda_out                = sda_out_q;
    assign sda_oe                 = sda_oe_q;
    assign conversion_rate_code_start             = conversion_rate_code_start_q;
    assign busy                   = status_q[STAT_BUSY];
    assign config_out             = cfg_q;
    assign conversion_rate_code   = rate_q;
    assign local_high_limit_bits  = lhl_q;
    assign remote_high_limit_bits = rhl_q;
    assign remote_low_limit_bits  = rll_q;
    assign remote_offset_bits     = rofs_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    AST_ONESHOT_RUN: assert property (
        clk_en && wr_stb && phys_ptr == REG_ONESHOT && cfg_q[CFG_STANDBY_SELECT] |=> conversion_rate_code_start_q ##1
        (!conversion_rate_code_start_q || !clk_en))
        else $error("Trigger write in standby did not give one start pulse.");
    AST_ONESHOT_NOSTORE: assert property (
        clk_en && wr_stb && ptr_q == REG_ONESHOT |=> $stable(cfg_q) && $stable(lhl_q)
        && $stable(rofs_q))
        else $error("Trigger write changed a stored register.");
    AST_ONESHOT_READ: assert property (
        phys_ptr == REG_ONESHOT |-> rd_data == 8'h00)
        else $error("Trigger register read not zero.");
    AST_TIMEOUT_IDLE: assert property (
        clk_en && ev.timeout && !ev.start |=> state_q == ST_IDLE && !sda_oe_q)
        else $error("Timeout did not return the target to idle.");
    AST_START_ABORT: assert property (
        clk_en && ev.start |=> !sda_oe_q)
        else $error("Start condition did not release the data line.");
    AST_START_ADDR: assert property (
        clk_en && ev.start |=> state_q == ST_ADDR && cnt_q == 4'h0)
        else $error("Byte after start not taken as address.");
    AST_ALIAS_WRITE: assert property (
        clk_en && wr_stb && ptr_q == REG_LHL_ALIAS |=> lhl_q == $past(rx_byte))
        else $error("Alias write missed the primary register.");
    AST_LOCAL_FMT: assert property (
        clk_en && conversion_rate_code_done |=> local_q == $past(local_temp_in))
        else $error("Local result not captured at conversion end.");
    AST_FRAC_OFF: assert property (
        !filt_on && phys_ptr == REG_RFRAC |-> rd_data[4:0] == 5'h00)
        else $error("Unfiltered fraction low bits not zero.");
    AST_FRAC_ON: assert property (
        filt_on && phys_ptr == REG_RFRAC |-> rd_data[7:3] == remote_q[4:0])
        else $error("Filtered fraction does not carry five bits.");
    AST_BUSY_HOLD: assert property (
        clk_en && busy && !one_shot |=> busy == !$past(conversion_rate_code_done))
        else $error("Busy did not follow the end of the conversion.");

    COV_ONESHOT: cover property (conversion_rate_code_start_q ##[1:50] conversion_rate_code_done);
    COV_READ_DONE: cover property (state_q == ST_RACK ##1 state_q == ST_IDLE);
    COV_TIMEOUT: cover property (ev.timeout);
    COV_ALIAS_WR: cover property (wr_stb && ptr_q == REG_CFG_ALIAS);

endmodule : tmr_regbank
`default_nettype wire

// ===== tmr_pkg.sv
package tmr_pkg;

    localparam logic [7:0] REG_LOCAL      = 8'h00;
    localparam logic [7:0] REG_REMOTE_OVER_LIMIT_FLAG      = 8'h01;
    localparam logic [7:0] REG_STATUS     = 8'h02;
    localparam logic [7:0] REG_CFG        = 8'h03;
    localparam logic [7:0] REG_RATE       = 8'h04;
    localparam logic [7:0] REG_LHL        = 8'h05;
    localparam logic [7:0] REG_RHL        = 8'h07;
    localparam logic [7:0] REG_RLL        = 8'h08;
    localparam logic [7:0] REG_CFG_ALIAS  = 8'h09;
    localparam logic [7:0] REG_RATE_ALIAS = 8'h0a;
    localparam logic [7:0] REG_LHL_ALIAS  = 8'h0b;
    localparam logic [7:0] REG_RHL_ALIAS  = 8'h0d;
    localparam logic [7:0] REG_RLL_ALIAS  = 8'h0e;
    localparam logic [7:0] REG_ONESHOT    = 8'h0f;
    localparam logic [7:0] REG_RFRAC      = 8'h10;
    localparam logic [7:0] REG_ROFS       = 8'h11;

    localparam logic [7:0] RST_CFG  = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h80;
    localparam logic [7:0] RST_LHL  = 8'h46;
    localparam logic [7:0] RST_RHL  = 8'h69;
    localparam logic [7:0] RST_RLL  = 8'h00;
    localparam logic [7:0] RST_ROFS = 8'h00;

    localparam int STAT_BUSY   = 7;
    localparam int STAT_LOVER  = 6;
    localparam int STAT_ROVER  = 4;
    localparam int STAT_RUNDER = 3;
    localparam int STAT_DFAULT = 2;
    localparam int STAT_REMOTE_CRITICAL_FLAG  = 1;
    localparam int CFG_STANDBY_SELECT    = 6;
    localparam int RATE_W      = 4;

    localparam int CLK_HZ         = 25_000_000;
    localparam int TIMEOUT_MIN_MS = 25;
    localparam int TIMEOUT_MAX_MS = 35;
    // The least figure of the window, rounded up to whole cycles.
    localparam int TIMEOUT_CYC    = (TIMEOUT_MIN_MS * CLK_HZ + 999) / 1000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_ACK   = 3'h2,
        ST_CMD   = 3'h3,
        ST_WDATA = 3'h4,
        ST_RDATA = 3'h5,
        ST_RACK  = 3'h6
    } tmr_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
        logic timeout;
    } tmr_bus_ev_t;

endpackage : tmr_pkg

// ===== tmr_bus_watch.sv
`timescale 1ns/1ns
`default_nettype none
module tmr_bus_watch
#(
    parameter int TIMEOUT_CYC = tmr_pkg::TIMEOUT_CYC
)
(
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output var  tmr_pkg::tmr_bus_ev_t ev
);
    import tmr_pkg::*;

    localparam int CW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(TIMEOUT_CYC - 1);

    logic [1:0]    scl_sync_q;
    logic [1:0]    sda_sync_q;
    logic          scl_prev_q;
    logic          sda_prev_q;
    logic [CW-1:0] low_cnt_q;
    logic [CW-1:0] low_cnt_d;
    tmr_bus_ev_t   ev_q;
    tmr_bus_ev_t   ev_d;

    wire scl_s      = scl_sync_q[1];
    wire sda_s      = sda_sync_q[1];
    wire both_high  = scl_s & sda_s;
    wire cnt_at_end = (low_cnt_q == CNT_LAST);

    // The count holds at TIMEOUT_CYC, one past CNT_LAST, so the idle reset fires once per low period.
    assign low_cnt_d = both_high ? '0 :
                       (low_cnt_q == CW'(TIMEOUT_CYC)) ? low_cnt_q : low_cnt_q + 1'b1;
    assign ev_d.start    = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign ev_d.stop     = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    assign ev_d.scl_rise = scl_s & ~scl_prev_q;
    assign ev_d.scl_fall = ~scl_s & scl_prev_q;
    assign ev_d.sda      = sda_s;
    assign ev_d.timeout  = cnt_at_end & ~both_high;
    assign ev            = ev_q;

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            low_cnt_q  <= '0;
            ev_q       <= '0;
        end
        else if (clk_en)
        begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
            low_cnt_q  <= low_cnt_d;
            ev_q       <= ev_d;
        end
    end

    AST_LOW_RESTART: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && both_high |=> low_cnt_q == '0)
        else $error("Low counter did not restart with both lines high.");

    AST_TIMEOUT_FIRE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && cnt_at_end && !both_high |=> ev_q.timeout)
        else $error("Timeout pulse missing at threshold.");

endmodule : tmr_bus_watch
`default_nettype wire

// ===== tmr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module tmr_host_model
(
    input  wire logic sda_oe,
    output wire logic scl_in,
    output wire logic sda_in
);
    logic scl_lo = 1'h0;
    logic sda_lo = 1'h0;

    // Both lines are open drain with pull-ups, so a released line reads high.
    assign scl_in = ~scl_lo;
    assign sda_in = ~(sda_lo | sda_oe);

    // One clock of 320 ns. SDA moves only while SCL is low, and the sample
    // is taken late in the high phase so that the target has long settled.
    task automatic clk_bit(input logic b, output logic s);
        #80 sda_lo = ~b;
        #80 scl_lo = 1'h0;
        #120 s = sda_in;
        #40 scl_lo = 1'h1;
    endtask : clk_bit

    task automatic start_cond();
        #80 sda_lo = 1'h0;
        #80 scl_lo = 1'h0;
        #80 sda_lo = 1'h1;
        #80 scl_lo = 1'h1;
    endtask : start_cond

    task automatic stop_cond();
        #80 sda_lo = 1'h1;
        #80 scl_lo = 1'h0;
        #80 sda_lo = 1'h0;
        #80;
    endtask : stop_cond

    task automatic send_bits(input logic [7:0] b, input int n);
        logic s;
        for (int i = 7; i > 7 - n; i--)
            clk_bit(b[i], s);
    endtask : send_bits

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        send_bits(b, 8);
        clk_bit(1'h1, s);
        ack = ~s;
    endtask : put_byte

    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'h1, b[i]);
        clk_bit(last, s);
    endtask : get_byte
endmodule : tmr_host_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import tmr_pkg::*;
    localparam logic [6:0] DEV = 7'h2a;
    logic        sys_clk   = 1'h0;
    logic        sys_rst   = 1'h1;
    logic        conversion_rate_code_done = 1'h0;
    logic        diode     = 1'h0;
    logic        crit      = 1'h0;
    logic        enh       = 1'h0;
    logic        clk_en    = 1'h1;
    logic [1:0]  filt      = 2'h0;
    logic [7:0]  ltemp     = 8'h00;
    logic [12:0] rtemp     = 13'h0000;
    wire         scl_in;
    wire         sda_in;
    logic        sda_out, sda_oe, conversion_rate_code_start, busy, ak;
    logic [7:0]  cfg, lhl, rhl, rll, rofs, rv;
    logic [3:0]  rate;
    int          n_errors = 0;
    int          checks   = 0;
    int          n_conversion_rate_code   = 0;
    int          k;
    logic [7:0]  rst_a [9] = '{8'h03, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0b, 8'h0d, 8'h0e, 8'h11};
    logic [7:0]  rst_v [9] = '{8'h00, 8'h46, 8'h69, 8'h00, 8'h00, 8'h46, 8'h69, 8'h00, 8'h00};
    logic [7:0]  al_a [6]  = '{8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h11};
    logic [7:0]  al_b [6]  = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h11};
    logic [7:0]  al_w [6]  = '{8'h5a, 8'h07, 8'h9c, 8'h33, 8'hf0, 8'h81};
    logic [7:0]  al_e [6]  = '{8'h42, 8'h07, 8'h9c, 8'h33, 8'hf0, 8'h81};

    tmr_regbank #(.DEV_ADDR(DEV), .TIMEOUT_CYC(200)) u_tmr_regbank (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .local_temp_in(ltemp),
        .remote_temp_in(rtemp), .diode_fault_in(diode), .remote_crit_in(crit),
        .conversion_rate_code_done(conversion_rate_code_done), .remote_filter_select(filt), .enhanced_resolution_select(enh),
        .conversion_rate_code_start(conversion_rate_code_start), .busy(busy), .config_out(cfg), .conversion_rate_code(rate),
        .local_high_limit_bits(lhl), .remote_high_limit_bits(rhl),
        .remote_low_limit_bits(rll), .remote_offset_bits(rofs));

    tmr_host_model u_tmr_host_model (.sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
        if (conversion_rate_code_start === 1'h1)
            n_conversion_rate_code++;

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [2:0] acks;
        u_tmr_host_model.start_cond();
        u_tmr_host_model.put_byte({DEV, 1'h0}, acks[2]);
        u_tmr_host_model.put_byte(a, acks[1]);
        u_tmr_host_model.put_byte(d, acks[0]);
        u_tmr_host_model.stop_cond();
        `CHK("write_acks", 3'h7, acks)
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [2:0] acks;
        u_tmr_host_model.start_cond();
        u_tmr_host_model.put_byte({DEV, 1'h0}, acks[2]);
        u_tmr_host_model.put_byte(a, acks[1]);
        u_tmr_host_model.start_cond();
        u_tmr_host_model.put_byte({DEV, 1'h1}, acks[0]);
        u_tmr_host_model.get_byte(1'h1, d);
        u_tmr_host_model.stop_cond();
        `CHK("read_acks", 3'h7, acks)
    endtask : rd

    task automatic pulse_done();
        @(negedge sys_clk);
        conversion_rate_code_done = 1'h1;
        @(negedge sys_clk);
        conversion_rate_code_done = 1'h0;
        repeat (2) @(negedge sys_clk);
    endtask : pulse_done

    initial
    begin
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'h0;
        repeat (6) @(negedge sys_clk);
        // Offsets 06 and 0c are never visited.
        for (int i = 0; i < 9; i++)
        begin
            rd(rst_a[i], rv);
            `CHK("reset_value", rst_v[i], rv)
        end
        for (int i = 0; i < 6; i++)
        begin
            wr(al_a[i], al_w[i]);
            rd(al_b[i], rv);
            `CHK("alias_readback", al_e[i], rv)
        end
        `CHK("reg_outputs", 44'h4279c33f081, {cfg, rate, lhl, rhl, rll, rofs})
        ltemp = 8'he7;
        rtemp = 13'h1236;
        diode = 1'h1;
        crit = 1'h1;
        wr(REG_ONESHOT, 8'ha5);
        rd(REG_STATUS, rv);
        `CHK("status_busy", 8'h80, rv)
        `CHK("start_pulses", 1, n_conversion_rate_code)
        pulse_done();
        `CHK("busy_cleared", 1'h0, busy)
        rd(REG_STATUS, rv);
        `CHK("status_done", 8'h4e, rv)
        wr(REG_ONESHOT, 8'h00);
        pulse_done();
        `CHK("start_pulses", 2, n_conversion_rate_code)
        rd(REG_ONESHOT, rv);
        `CHK("trigger_read", 8'h00, rv)
        rd(REG_LOCAL, rv);
        `CHK("local_temp", 8'he7, rv)
        rd(REG_REMOTE_OVER_LIMIT_FLAG, rv);
        `CHK("remote_high", 8'h91, rv)
        for (int i = 0; i < 5; i++)
        begin
            filt = 2'(i);
            enh = (i == 4);
            rd(REG_RFRAC, rv);
            `CHK("remote_frac", (filt != 2'h0 || enh) ? 8'hb0 : 8'ha0, rv)
        end
        u_tmr_host_model.start_cond();
        u_tmr_host_model.put_byte({7'h2b, 1'h0}, ak);
        u_tmr_host_model.stop_cond();
        `CHK("foreign_ack", 1'h0, ak)
        // A start in mid-byte must drop the half-written limit.
        u_tmr_host_model.start_cond();
        u_tmr_host_model.put_byte({DEV, 1'h0}, ak);
        u_tmr_host_model.put_byte(REG_LHL, ak);
        u_tmr_host_model.send_bits(8'h11, 4);
        wr(REG_RHL, 8'h22);
        `CHK("aborted_write", 8'h9c, lhl)
        `CHK("write_after_start", 8'h22, rhl)
        u_tmr_host_model.start_cond();
        u_tmr_host_model.send_bits({DEV, 1'h0}, 8);
        repeat (20) @(negedge sys_clk);
        `CHK("ack_holding", 1'h1, sda_oe)
        `CHK("sda_drive", 1'h0, sda_out)
        k = 0;
        // The host keeps SCL low until the target releases SDA, for at most 400 cycles.
        while (sda_oe !== 1'h0 && k < 400)
        begin
            @(negedge sys_clk);
            k++;
        end
        `CHK("timeout_release", 1'h1, (k >= 140 && k <= 220))
        u_tmr_host_model.stop_cond();
        rd(REG_RHL, rv);
        `CHK("after_timeout", 8'h22, rv)
        // A completion pulse while the clock enable is low must not be captured.
        ltemp = 8'h19;
        clk_en = 1'h0;
        pulse_done();
        clk_en = 1'h1;
        rd(REG_LOCAL, rv);
        `CHK("frozen_capture", 8'he7, rv)
        sys_rst = 1'h1;
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'h0;
        repeat (6) @(negedge sys_clk);
        `CHK("mid_rst", {RST_CFG, RST_LHL, RST_RHL, RST_ROFS}, {cfg, lhl, rhl, rofs})
        `CHK("mid_rst_busy", 1'h0, busy)
        rd(REG_RHL_ALIAS, rv);
        `CHK("mid_rst_alias", RST_RHL, rv)
        wrap_up();
    end

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
